// *** verilog/abmc_top.sv ***
// Boot-mode selection, start-up configuration and boot status register.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Pattern 01 at reset edge selects alternate boot
// - Pattern 10 bootstrap loader, 11 normal reset
// - Boot modes map test flash at zero
// - Data-only flash: no fetch in boot modes; extension flash: all while enabled
// - Alternate boot block never reprogrammable from ALT_BOOT_FLAG
// - Watchdog stays disabled in boot modes
// - Watchdog reset in ALT_BOOT_FLAG becomes software reset
// - Boot entry loads fixed CPU start values
// - ROM enable set; byte-high disable from bus width
// - Bus config zero cleared when access pin high
// - Access pin low: bus active, lengthen, type
// - Peripheral select 002D with enable bit set
// - Peripheral settings writable until end of init
// - Alternate boot left only through a reset
// - Sum operands, invert low byte, compare reference
// - Status bit 5 shows alternate boot selected
// - Status bit read-only, held until reset
// - Loader owns dual-port RAM from 00'FA40h
// - CAN receive pin never a user output in boot modes
module abmc_top #(
    parameter logic [15:0] NORM_SYSCFG = 16'h0000,
    parameter logic [15:0] NORM_SP = 16'hFC00,
    parameter logic [15:0] NORM_STACK_OVERFLOW_LIMIT = 16'hFA00,
    parameter logic [15:0] NORM_STACK_UNDERFLOW_LIMIT = 16'hFC00,
    parameter logic [15:0] NORM_CP = 16'hFC00,
    parameter logic [15:0] NORM_XPSEL = 16'h0000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic external_reset_pin,
    input wire logic [7:0] port0_low_config_pins,
    input wire logic ext_access_pin,
    input wire logic end_of_init_instruction,
    input wire logic sw_reset_req,
    input wire logic wdt_reset_req,
    input wire abmc_pkg::abmc_acc_req_t acc_req,
    input wire abmc_pkg::abmc_sig_req_t sig_req,
    input wire logic user_can_oe,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output abmc_pkg::abmc_mode_t boot_mode,
    output abmc_pkg::abmc_cpu_init_t cpu_init,
    output logic [15:0] ext_periph_select,
    output logic wdt_enable,
    output logic test_flash_at_zero,
    output logic extension_code_flash_enable,
    output logic acc_done,
    output logic acc_ok,
    output logic loader_area_hit,
    output logic sw_reset_out,
    output logic sig_done,
    output logic sig_pass,
    output logic [23:0] start_vector,
    output logic can_rx_oe
);
    abmc_pkg::abmc_mode_t mode_q, mode_d;
    abmc_pkg::abmc_cpu_init_t init_q, init_d, boot_init, norm_init;
    logic pin_q;
    logic alt_flag_q, alt_flag_d;
    logic end_of_init_instruction_q;
    logic [15:0] xpsel_q, xpsel_d;
    logic [15:0] rdata_q, rdata_d;

    wire pin_rise = external_reset_pin & ~pin_q;
    wire [1:0] pat = port0_low_config_pins[abmc_pkg::MODE_LO +: 2];
    wire [1:0] bus_type_field = port0_low_config_pins[abmc_pkg::BUS_TYPE_FIELD_LO +: 2];
    // An 8-bit bus type leaves the high byte lane unused.
    wire byte_high_disable = ~bus_type_field[0];
    // Watchdog reset inside alternate boot is folded into software reset.
    // watchdog as reset
    wire wdt_as_sw = wdt_reset_req & (mode_q == abmc_pkg::MODE_ALT_BOOT);
    wire any_sw_reset = sw_reset_req | wdt_as_sw;
    wire boot_d = (mode_d == abmc_pkg::MODE_STD_BOOT) | (mode_d == abmc_pkg::MODE_ALT_BOOT);
    wire boot_q = (mode_q == abmc_pkg::MODE_STD_BOOT) | (mode_q == abmc_pkg::MODE_ALT_BOOT);
    wire alt_q = (mode_q == abmc_pkg::MODE_ALT_BOOT);

    always_comb
    begin
        mode_d = mode_q;
        if (pin_rise)
        begin
            case (pat)
                abmc_pkg::PAT_ALT: mode_d = abmc_pkg::MODE_ALT_BOOT;
                abmc_pkg::PAT_STD: mode_d = abmc_pkg::MODE_STD_BOOT;
                abmc_pkg::PAT_NORM: mode_d = abmc_pkg::MODE_NORMAL;
                default: mode_d = abmc_pkg::MODE_TEST;
            endcase
        end
        else if (any_sw_reset)
            mode_d = abmc_pkg::MODE_NORMAL;
    end

    assign alt_flag_d = pin_rise ? (pat == abmc_pkg::PAT_ALT)
                      : (any_sw_reset ? 1'b0 : alt_flag_q);

    assign boot_init.syscfg = abmc_pkg::BOOT_SYSCFG | (16'(byte_high_disable) << abmc_pkg::BYTE_HIGH_DISABLE_BIT)
                            | (16'h0001 << abmc_pkg::INTERNAL_ROM_ENABLE_BIT);
    assign boot_init.sp = abmc_pkg::BOOT_SP;
    assign boot_init.stack_overflow_limit = abmc_pkg::BOOT_STACK_OVERFLOW_LIMIT;
    assign boot_init.stack_underflow_limit = abmc_pkg::BOOT_CP;
    assign boot_init.cp = abmc_pkg::BOOT_CP;
    assign boot_init.bus_config_zero = ext_access_pin ? abmc_pkg::BOOT_BUSCON
                             : ((16'h0001 << abmc_pkg::BUSACT_BIT)
                              | (16'h0001 << abmc_pkg::ALECTL_BIT)
                              | (16'(bus_type_field) << abmc_pkg::BUS_TYPE_FIELD_LO));
    assign norm_init = '{NORM_SYSCFG, NORM_SP, NORM_STACK_OVERFLOW_LIMIT, NORM_STACK_UNDERFLOW_LIMIT, NORM_CP,
                         abmc_pkg::BOOT_BUSCON};

    wire wr_sys = reg_wr & (reg_addr == abmc_pkg::ADDR_SYSCFG) & ~end_of_init_instruction_q;
    wire wr_xps = reg_wr & (reg_addr == abmc_pkg::ADDR_XPSEL) & ~end_of_init_instruction_q;

    always_comb
    begin
        init_d = init_q;
        xpsel_d = xpsel_q;
        if (pin_rise | any_sw_reset)
        begin
            init_d = boot_d ? boot_init : norm_init;
            xpsel_d = boot_d ? abmc_pkg::BOOT_XPSEL : NORM_XPSEL;
        end
        else
        begin
            if (wr_sys)
                init_d.syscfg = reg_wdata;
            if (wr_xps)
                xpsel_d = reg_wdata;
        end
    end

    wire xfl_en_d = init_d.syscfg[abmc_pkg::EXT_PERIPH_ENABLE_BIT] & xpsel_d[abmc_pkg::XFL_SEL_BIT];

    // Register read mux; the status word carries only the flag bit.
    always_comb
    begin
        rdata_d = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                abmc_pkg::ADDR_STATUS: rdata_d[abmc_pkg::ABM_BIT] = alt_flag_q;
                abmc_pkg::ADDR_SYSCFG: rdata_d = init_q.syscfg;
                abmc_pkg::ADDR_XPSEL: rdata_d = xpsel_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    wire a_ifl = (acc_req.addr >= abmc_pkg::IFL_LO) & (acc_req.addr <= abmc_pkg::IFL_HI);
    wire a_xfl = (acc_req.addr >= abmc_pkg::XFL_LO) & (acc_req.addr <= abmc_pkg::XFL_HI);
    wire a_blk = (acc_req.addr >= abmc_pkg::ABMBLK_LO) & (acc_req.addr <= abmc_pkg::ABMBLK_HI);
    wire a_ldr = (acc_req.addr >= abmc_pkg::LDR_LO) & (acc_req.addr <= abmc_pkg::LDR_HI);
    wire deny_fetch = boot_q & a_ifl & (acc_req.kind == abmc_pkg::ACC_FETCH);
    wire deny_xfl = a_xfl & ~extension_code_flash_enable;
    wire deny_prog = alt_q & a_blk & (acc_req.kind == abmc_pkg::ACC_PROG);
    wire acc_ok_d = acc_req.valid & ~deny_fetch & ~deny_xfl & ~deny_prog;
    wire ldr_hit_d = acc_req.valid & boot_q & a_ldr & (acc_req.kind == abmc_pkg::ACC_WRITE);

    wire [15:0] sig_sum = sig_req.op0 + sig_req.op1;
    wire [15:0] sig_word = {sig_sum[15:8], ~sig_sum[7:0]};
    wire sig_ok = (sig_word == sig_req.refw);
    wire [23:0] vec_d = sig_req.alt ? abmc_pkg::ALT_VEC : abmc_pkg::USER_VEC;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_q <= 1'b0;
            mode_q <= abmc_pkg::MODE_NORMAL;
            alt_flag_q <= 1'b0;
            end_of_init_instruction_q <= 1'b0;
            init_q <= '0;
            xpsel_q <= 16'h0000;
        end
        else
        begin
            pin_q <= external_reset_pin;
            mode_q <= mode_d;
            alt_flag_q <= alt_flag_d;
            end_of_init_instruction_q <= (pin_rise | any_sw_reset) ? 1'b0 : (end_of_init_instruction_q | end_of_init_instruction);
            init_q <= init_d;
            xpsel_q <= xpsel_d;
        end
    end

    // Mode-derived outputs are registered copies of the next state, so they track state without lag; the rest follow their inputs one cycle late.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_q <= 16'h0000;
            wdt_enable <= 1'b0;
            test_flash_at_zero <= 1'b0;
            extension_code_flash_enable <= 1'b0;
            acc_done <= 1'b0;
            acc_ok <= 1'b0;
            loader_area_hit <= 1'b0;
            sw_reset_out <= 1'b0;
            sig_done <= 1'b0;
            sig_pass <= 1'b0;
            start_vector <= 24'h000000;
            can_rx_oe <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            wdt_enable <= ~boot_d;
            test_flash_at_zero <= boot_d;
            extension_code_flash_enable <= xfl_en_d;
            acc_done <= acc_req.valid;
            acc_ok <= acc_ok_d;
            loader_area_hit <= ldr_hit_d;
            sw_reset_out <= any_sw_reset;
            sig_done <= sig_req.valid;
            sig_pass <= sig_req.valid & sig_ok;
            start_vector <= vec_d;
            can_rx_oe <= user_can_oe & ~boot_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign boot_mode = mode_q;
    assign cpu_init = init_q;
    assign ext_periph_select = xpsel_q;

    default clocking dflt @(posedge clk); endclocking
    default disable iff (!resetn);

    a_alt_entry: assert property (
        pin_rise && pat == abmc_pkg::PAT_ALT |=> alt_q && alt_flag_q)
        else $error("alternate pattern did not enter alternate boot");
    a_std_entry: assert property (
        pin_rise && pat == abmc_pkg::PAT_STD |=> boot_mode == abmc_pkg::MODE_STD_BOOT && !alt_flag_q)
        else $error("bootstrap pattern decoded wrongly");
    a_flag_holds: assert property (
        alt_flag_q && !pin_rise && !any_sw_reset |=> alt_flag_q)
        else $error("status flag lost without reset");
    a_status_read: assert property (
        reg_rd && reg_addr == abmc_pkg::ADDR_STATUS |=> reg_rdata == (16'($past(alt_flag_q)) << 5))
        else $error("status word wrong");
    a_boot_values: assert property (
        pin_rise && pat[1] != pat[0] |=> cpu_init.sp == 16'hFA40 && cpu_init.stack_overflow_limit == 16'hFC00
        && cpu_init.cp == 16'hFA00 && cpu_init.syscfg[10] && ext_periph_select == 16'h002D)
        else $error("boot start values wrong");
    a_wdt_off: assert property (
        boot_q |-> !wdt_enable)
        else $error("watchdog enabled in boot mode");
    a_wdt_swrst: assert property (
        wdt_reset_req && alt_q && !pin_rise |=> sw_reset_out && boot_mode == abmc_pkg::MODE_NORMAL)
        else $error("watchdog reset not turned into software reset");
    a_no_fetch: assert property (
        acc_req.valid && boot_q && a_ifl && acc_req.kind == abmc_pkg::ACC_FETCH |=> acc_done && !acc_ok)
        else $error("fetch from data-only flash allowed");
    a_blk_locked: assert property (
        acc_req.valid && alt_q && a_blk && acc_req.kind == abmc_pkg::ACC_PROG |=> !acc_ok)
        else $error("alternate boot block programmable");
    a_sig_result: assert property (
        sig_req.valid |=> sig_done && sig_pass == $past(sig_ok))
        else $error("signature result wrong");
    a_end_of_init_instruction_lock: assert property (
        end_of_init_instruction_q && !pin_rise && !any_sw_reset |=> $stable(ext_periph_select))
        else $error("peripheral select changed after end of init");
    a_can_input: assert property (
        boot_q |-> !can_rx_oe)
        else $error("CAN receive pin driven in boot mode");

    // Start-up values are judged in the cycle after the pin edge that loads them,
    // since cpu_init and ext_periph_select are state registers loaded on that edge.
    a_tflash_map: assert property (
        boot_q |-> test_flash_at_zero)
        else $error("test flash not mapped at zero in boot mode");
    a_xfl_gated: assert property (
        acc_req.valid && a_xfl && !extension_code_flash_enable |=> acc_done && !acc_ok)
        else $error("extension flash reachable while disabled");
    a_rom_enable: assert property (
        pin_rise && pat[1] != pat[0]
        |=> cpu_init.syscfg[10] && cpu_init.syscfg[9] == $past(byte_high_disable))
        else $error("boot system configuration bits wrong");
    a_bus_ea_high: assert property (
        pin_rise && pat[1] != pat[0] && ext_access_pin |=> cpu_init.bus_config_zero == 16'h0000)
        else $error("bus config zero not cleared with access pin high");
    a_bus_ea_low: assert property (
        pin_rise && pat[1] != pat[0] && !ext_access_pin
        |=> cpu_init.bus_config_zero[10:9] == 2'h3 && cpu_init.bus_config_zero[7:6] == $past(bus_type_field))
        else $error("bus config zero wrong with access pin low");
    a_ext_periph_enable_set: assert property (
        pin_rise && pat[1] != pat[0] |=> cpu_init.syscfg[2] && extension_code_flash_enable)
        else $error("peripheral enable not set on boot entry");
    a_syscfg_lock: assert property (
        end_of_init_instruction_q && !pin_rise && !any_sw_reset |=> $stable(cpu_init.syscfg))
        else $error("system configuration changed after end of init");
    a_sw_pulse: assert property (
        sw_reset_req |=> sw_reset_out)
        else $error("software reset request not passed on");
    a_stay_alt: assert property (
        alt_q && !pin_rise && !any_sw_reset |=> boot_mode == abmc_pkg::MODE_ALT_BOOT)
        else $error("alternate boot left without a reset");
    a_norm_entry: assert property (
        pin_rise && pat == abmc_pkg::PAT_NORM |=> boot_mode == abmc_pkg::MODE_NORMAL && wdt_enable)
        else $error("normal pattern decoded wrongly");
    a_start_vec: assert property (
        sig_req.valid && sig_req.alt |=> start_vector == 24'h090000)
        else $error("alternate start vector wrong");
    a_flag_clear: assert property (
        any_sw_reset && !pin_rise |=> !alt_flag_q && boot_mode == abmc_pkg::MODE_NORMAL)
        else $error("software reset did not clear boot state");
    a_loader_hit: assert property (
        acc_req.valid && boot_q && a_ldr && acc_req.kind == abmc_pkg::ACC_WRITE
        |=> loader_area_hit)
        else $error("loader area write not flagged");
    a_mode_held: assert property (
        !pin_rise && !any_sw_reset |=> $stable(boot_mode))
        else $error("boot mode changed without a reset");

    c_alt_boot: cover property (pin_rise && pat == abmc_pkg::PAT_ALT);
    c_std_boot: cover property (pin_rise && pat == abmc_pkg::PAT_STD);
    c_sig_alt: cover property (sig_req.valid && sig_req.alt && sig_ok);
    c_wr_locked: cover property (end_of_init_instruction_q && reg_wr && reg_addr == abmc_pkg::ADDR_XPSEL);
    c_test_mode: cover property (pin_rise && pat == 2'h0);
endmodule
`default_nettype wire

// *** verilog/abmc_pkg.sv ***
// Shared constants and types of the alternate boot mode control block.
package abmc_pkg;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_STD_BOOT, MODE_ALT_BOOT, MODE_TEST} abmc_mode_t;
    typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_FETCH, ACC_PROG} abmc_kind_t;
    typedef struct packed {
        logic valid;
        abmc_kind_t kind;
        logic [23:0] addr;
    } abmc_acc_req_t;
    typedef struct packed {
        logic valid;
        logic alt;
        logic [15:0] op0;
        logic [15:0] op1;
        logic [15:0] refw;
    } abmc_sig_req_t;
    typedef struct packed {
        logic [15:0] syscfg;
        logic [15:0] sp;
        logic [15:0] stack_overflow_limit;
        logic [15:0] stack_underflow_limit;
        logic [15:0] cp;
        logic [15:0] bus_config_zero;
    } abmc_cpu_init_t;
    localparam int MODE_LO = 4;
    localparam int BUS_TYPE_FIELD_LO = 6;
    localparam logic [1:0] PAT_ALT = 2'h1;
    localparam logic [1:0] PAT_STD = 2'h2;
    localparam logic [1:0] PAT_NORM = 2'h3;
    localparam logic [15:0] ADDR_STATUS = 16'hFE0A;
    localparam logic [15:0] ADDR_SYSCFG = 16'hFE12;
    localparam logic [15:0] ADDR_XPSEL = 16'hFE14;
    localparam int ABM_BIT = 5;
    localparam int EXT_PERIPH_ENABLE_BIT = 2;
    localparam int BYTE_HIGH_DISABLE_BIT = 9;
    localparam int INTERNAL_ROM_ENABLE_BIT = 10;
    localparam int BUSACT_BIT = 10;
    localparam int ALECTL_BIT = 9;
    localparam int XFL_SEL_BIT = 5;
    localparam logic [15:0] BOOT_SYSCFG = 16'h0404;
    localparam logic [15:0] BOOT_SP = 16'hFA40;
    localparam logic [15:0] BOOT_STACK_OVERFLOW_LIMIT = 16'hFC00;
    localparam logic [15:0] BOOT_CP = 16'hFA00;
    localparam logic [15:0] BOOT_BUSCON = 16'h0000;
    localparam logic [15:0] BOOT_XPSEL = 16'h002D;
    localparam logic [23:0] IFL_LO = 24'h010000;
    localparam logic [23:0] IFL_HI = 24'h08FFFF;
    localparam logic [23:0] XFL_LO = 24'h090000;
    localparam logic [23:0] XFL_HI = 24'h0DFFFF;
    localparam logic [23:0] ABMBLK_LO = 24'h090000;
    localparam logic [23:0] ABMBLK_HI = 24'h09FFFF;
    localparam logic [23:0] LDR_LO = 24'h00FA40;
    localparam logic [23:0] LDR_HI = 24'h00FABF;
    localparam logic [23:0] USER_VEC = 24'h000000;
    localparam logic [23:0] ALT_VEC = 24'h090000;
endpackage

// *** testbench/abmc_boot_model.sv ***
// Model of the reset-configuration pins and of the boot images held in flash.
`timescale 1ns/10ps
`default_nettype none
module abmc_boot_model (
    input wire logic clk,
    output logic external_reset_pin,
    output logic [7:0] port0_low_config_pins,
    output logic ext_access_pin
);
    logic [15:0] user_w [3] = '{16'hA5A5, 16'h0001, 16'hA559};
    logic [15:0] alt_w [3] = '{16'h1234, 16'h0F0F, 16'h21BC};

    initial
    begin
        external_reset_pin = 1'b0;
        port0_low_config_pins = 8'hFF;
        ext_access_pin = 1'b1;
    end

    // The boot images raise no interrupt; this model has no interrupt source at all.
    // Pins are static levels; hw_reset changes them only while the reset pin is low.
    task automatic hw_reset(input logic [1:0] pat, input logic [1:0] bus_type_field, input logic ea);
        @(posedge clk);
        external_reset_pin <= 1'b0;
        port0_low_config_pins <= {bus_type_field, pat, 4'hF};
        ext_access_pin <= ea;
        @(posedge clk);
        external_reset_pin <= 1'b1;
        @(posedge clk);
    endtask

    task automatic set_pins(input logic [7:0] p);
        @(posedge clk);
        port0_low_config_pins <= p;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_alternate_boot_mode_control.sv ***
// Self-checking bench of the boot-mode selection block.
`timescale 1ns/10ps
`default_nettype none
module tb_alternate_boot_mode_control;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic end_of_init_instruction = 1'b0;
    logic sw_reset_req = 1'b0;
    logic wdt_reset_req = 1'b0;
    logic user_can_oe = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] rd;
    abmc_pkg::abmc_acc_req_t acc_req = '0;
    abmc_pkg::abmc_sig_req_t sig_req = '0;
    wire logic pin;
    wire logic [7:0] cfg;
    wire logic ea;
    logic [15:0] reg_rdata, ext_periph_select;
    abmc_pkg::abmc_mode_t boot_mode;
    abmc_pkg::abmc_cpu_init_t ci;
    logic wdt_enable, test_flash_at_zero, extension_code_flash_enable, acc_done, acc_ok;
    logic loader_area_hit, sw_reset_out, sig_done, sig_pass, can_rx_oe;
    logic [23:0] start_vector;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #10 clk = ~clk;

    abmc_boot_model abmc_boot_model_i (.clk(clk), .external_reset_pin(pin),
        .port0_low_config_pins(cfg), .ext_access_pin(ea));

    abmc_top abmc_top_i (.clk(clk), .resetn(resetn), .external_reset_pin(pin),
        .port0_low_config_pins(cfg), .ext_access_pin(ea),
        .end_of_init_instruction(end_of_init_instruction), .sw_reset_req(sw_reset_req),
        .wdt_reset_req(wdt_reset_req), .acc_req(acc_req), .sig_req(sig_req),
        .user_can_oe(user_can_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_mode(boot_mode),
        .cpu_init(ci), .ext_periph_select(ext_periph_select), .wdt_enable(wdt_enable),
        .test_flash_at_zero(test_flash_at_zero), .extension_code_flash_enable(extension_code_flash_enable),
        .acc_done(acc_done), .acc_ok(acc_ok), .loader_area_hit(loader_area_hit),
        .sw_reset_out(sw_reset_out), .sig_done(sig_done), .sig_pass(sig_pass),
        .start_vector(start_vector), .can_rx_oe(can_rx_oe));

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic acc(input abmc_pkg::abmc_kind_t k, input logic [23:0] a, input logic ok,
        input logic hit);
        @(posedge clk);
        acc_req <= '{valid: 1'b1, kind: k, addr: a};
        @(posedge clk);
        acc_req <= '0;
        #1;
        chk("acc_done", 24'h000001, 24'(acc_done));
        chk("acc_ok", 24'(ok), 24'(acc_ok));
        chk("loader_area_hit", 24'(hit), 24'(loader_area_hit));
    endtask

    task automatic sig(input logic alt, input logic [15:0] o0, input logic [15:0] o1,
        input logic [15:0] r);
        logic [15:0] s;
        s = o0 + o1;
        @(posedge clk);
        sig_req <= '{valid: 1'b1, alt: alt, op0: o0, op1: o1, refw: r};
        @(posedge clk);
        sig_req <= '0;
        #1;
        chk("sig_done", 24'h000001, 24'(sig_done));
        chk("sig_pass", 24'({s[15:8], ~s[7:0]} == r), 24'(sig_pass));
        chk("start_vector", alt ? 24'h090000 : 24'h000000, start_vector);
    endtask

    task automatic t_alt_entry();
        abmc_boot_model_i.hw_reset(2'h1, 2'h2, 1'b1);
        #1;
        chk("mode", 24'(abmc_pkg::MODE_ALT_BOOT), 24'(boot_mode));
        chk("sp", 24'h00FA40, 24'(ci.sp));
        chk("stack_overflow_limit", 24'h00FC00, 24'(ci.stack_overflow_limit));
        chk("stack_underflow_limit", 24'h00FA00, 24'(ci.stack_underflow_limit));
        chk("cp", 24'h00FA00, 24'(ci.cp));
        chk("syscfg", 24'h000604, 24'(ci.syscfg));
        chk("bus_config_zero", 24'h000000, 24'(ci.bus_config_zero));
        chk("xpsel", 24'h00002D, 24'(ext_periph_select));
        chk("wdt_enable", 24'h000000, 24'(wdt_enable));
        chk("tflash", 24'h000001, 24'(test_flash_at_zero));
        chk("can_rx_oe", 24'h000000, 24'(can_rx_oe));
        reg_read(16'hFE0A, rd);
        chk("status", 24'h000020, 24'(rd));
        reg_write(16'hFE0A, 16'h0000);
        reg_read(16'hFE0A, rd);
        chk("status ro", 24'h000020, 24'(rd));
        reg_read(16'hFE00, rd);
        chk("unmapped", 24'h000000, 24'(rd));
        abmc_boot_model_i.set_pins(8'hFF);
        #1;
        chk("mode held", 24'(abmc_pkg::MODE_ALT_BOOT), 24'(boot_mode));
    endtask

    task automatic t_access_sig();
        acc(abmc_pkg::ACC_FETCH, 24'h010000, 1'b0, 1'b0);
        acc(abmc_pkg::ACC_READ, 24'h08FFFF, 1'b1, 1'b0);
        acc(abmc_pkg::ACC_FETCH, 24'h0DFFFF, 1'b1, 1'b0);
        acc(abmc_pkg::ACC_PROG, 24'h09FFFF, 1'b0, 1'b0);
        acc(abmc_pkg::ACC_PROG, 24'h0A0000, 1'b1, 1'b0);
        acc(abmc_pkg::ACC_WRITE, 24'h00FABF, 1'b1, 1'b1);
        acc(abmc_pkg::ACC_WRITE, 24'h00FAC0, 1'b1, 1'b0);
        sig(1'b1, abmc_boot_model_i.alt_w[0], abmc_boot_model_i.alt_w[1],
            abmc_boot_model_i.alt_w[2]);
        sig(1'b0, abmc_boot_model_i.user_w[0], abmc_boot_model_i.user_w[1],
            abmc_boot_model_i.user_w[2]);
        sig(1'b1, 16'hFFFF, 16'h0001, 16'h00FE);
    endtask

    task automatic t_periph();
        reg_write(16'hFE12, 16'h0600);
        chk("extension_code_flash off", 24'h000000, 24'(extension_code_flash_enable));
        acc(abmc_pkg::ACC_READ, 24'h090000, 1'b0, 1'b0);
        reg_write(16'hFE14, 16'h0025);
        chk("xpsel wr", 24'h000025, 24'(ext_periph_select));
        chk("extension_code_flash still off", 24'h000000, 24'(extension_code_flash_enable));
        reg_write(16'hFE12, 16'h0604);
        chk("extension_code_flash on", 24'h000001, 24'(extension_code_flash_enable));
        reg_read(16'hFE12, rd);
        chk("syscfg rd", 24'h000604, 24'(rd));
        @(posedge clk);
        end_of_init_instruction <= 1'b1;
        @(posedge clk);
        end_of_init_instruction <= 1'b0;
        reg_write(16'hFE14, 16'h0000);
        chk("xpsel locked", 24'h000025, 24'(ext_periph_select));
        reg_write(16'hFE12, 16'h0000);
        chk("syscfg locked", 24'h000604, 24'(ci.syscfg));
    endtask

    task automatic t_wdt_modes();
        @(posedge clk);
        wdt_reset_req <= 1'b1;
        @(posedge clk);
        wdt_reset_req <= 1'b0;
        #1;
        chk("sw_reset_out", 24'h000001, 24'(sw_reset_out));
        chk("mode exit", 24'(abmc_pkg::MODE_NORMAL), 24'(boot_mode));
        reg_read(16'hFE0A, rd);
        chk("status clr", 24'h000000, 24'(rd));
        abmc_boot_model_i.hw_reset(2'h2, 2'h1, 1'b0);
        #1;
        chk("mode std", 24'(abmc_pkg::MODE_STD_BOOT), 24'(boot_mode));
        chk("bus_config_zero ea", 24'h000640, 24'(ci.bus_config_zero));
        chk("syscfg std", 24'h000404, 24'(ci.syscfg));
        @(posedge clk);
        sw_reset_req <= 1'b1;
        @(posedge clk);
        sw_reset_req <= 1'b0;
        #1;
        chk("sw_reset_out sw", 24'h000001, 24'(sw_reset_out));
        chk("mode sw", 24'(abmc_pkg::MODE_NORMAL), 24'(boot_mode));
        abmc_boot_model_i.hw_reset(2'h3, 2'h0, 1'b1);
        @(posedge clk);
        #1;
        chk("mode norm", 24'(abmc_pkg::MODE_NORMAL), 24'(boot_mode));
        chk("wdt norm", 24'h000001, 24'(wdt_enable));
        chk("can norm", 24'h000001, 24'(can_rx_oe));
        abmc_boot_model_i.hw_reset(2'h0, 2'h0, 1'b1);
        #1;
        chk("mode test", 24'(abmc_pkg::MODE_TEST), 24'(boot_mode));
        reg_read(16'hFE0A, rd);
        chk("status test", 24'h000000, 24'(rd));
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // A run far longer than the scenarios need means a hang.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            final_report();
        end
    end

    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_alt_entry();
        t_access_sig();
        t_periph();
        t_wdt_modes();
        final_report();
    end
endmodule
`default_nettype wire
